// [include/ascp_pkg.sv]
// Constants, field layout and types of the converter configuration logic.
// Assumes a single 250 MHz reference clock; all pins arrive asynchronously.

package ascp_pkg;

  localparam int CFG_W = 9;
  localparam int START_BIT = 8;
  localparam int RANGE_BIP_BIT = 7;
  localparam int RANGE_WIDE_BIT = 6;
  localparam int PD_BIT = 5;
  localparam int MODE_LP_BIT = 4;
  localparam int MODE_FAST_BIT = 3;
  localparam int CODING_BIT = 2;
  localparam int WRITABLE_LO = 2;
  localparam logic [CFG_W-1:0] CFG_RESET = 9'h000;
  localparam logic [3:0] FRAME_LEN = 4'h9;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;

  // Link clock figures, in kHz
  localparam int REF_CLK_KHZ = 250000;
  localparam int CFG_SCLK_MAX_KHZ = 40000;
  localparam int SAMPLES_PER_HALF = REF_CLK_KHZ / (2 * CFG_SCLK_MAX_KHZ);

  // Pin bundle positions before synchronisation
  localparam int PIN_SPSEL = 0;
  localparam int PIN_HWSEL = 1;
  localparam int PIN_BIP = 2;
  localparam int PIN_WIDE = 3;
  localparam int PIN_PD = 4;
  localparam int PIN_LP = 5;
  localparam int PIN_FAST = 6;
  localparam int PIN_COD = 7;
  localparam int PIN_SIN = 8;
  localparam int PIN_SCLK = 9;
  localparam int PIN_SELN = 10;
  localparam int PIN_INV = 11;
  localparam int NPINS = 12;
  localparam logic [NPINS-1:0] PINS_RESET = 12'h000;

  typedef enum logic [1:0] {
    ASCP_RANGE_UNI5,
    ASCP_RANGE_UNI10,
    ASCP_RANGE_BIP5,
    ASCP_RANGE_BIP10
  } ascp_range_t;

  typedef enum logic [1:0] {
    ASCP_MODE_NORMAL,
    ASCP_MODE_IMPULSE,
    ASCP_MODE_WARP
  } ascp_mode_t;

  typedef enum logic [1:0] {
    ASCP_SH_IDLE,
    ASCP_SH_LOAD,
    ASCP_SH_SKIP
  } ascp_sh_state_t;

endpackage

// [include/ascp_cfg_if.sv]
// Carrier between the configuration top and its frame shifter.
// Assumes both ends run on the same reference clock.
`timescale 1ns/1ps
`default_nettype none

interface ascp_cfg_if;
  import ascp_pkg::*;
  logic port_active;
  logic sel_n;
  logic edge_pulse;
  logic data_bit;
  logic frame_done;
  logic [CFG_W-1:0] frame;

  modport ctrl (
    output port_active,
    output sel_n,
    output edge_pulse,
    output data_bit,
    input frame_done,
    input frame
  );

  modport shifter (
    input port_active,
    input sel_n,
    input edge_pulse,
    input data_bit,
    output frame_done,
    output frame
  );
endinterface

`default_nettype wire

// [design/ascp_shift.sv]
// Nine-bit configuration frame shifter.
// Assumes edge_pulse is one cycle per active serial clock edge.
`timescale 1ns/1ps
`default_nettype none

module ascp_shift
  import ascp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  ascp_cfg_if.shifter cfg
);

  typedef struct packed {
    ascp_sh_state_t state;
    logic [CFG_W-1:0] shreg;
    logic [3:0] count;
    logic done;
  } ascp_sh_t;

  ascp_sh_t st_ff;
  ascp_sh_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (!cfg.port_active || cfg.sel_n) begin
      // Deselect aborts any partial frame
      nxt_st.state = ASCP_SH_IDLE;
      nxt_st.count = CNT_ZERO;
    end else if (cfg.edge_pulse) begin
      case (st_ff.state)
        ASCP_SH_IDLE: begin
          if (cfg.data_bit) begin
            nxt_st.state = ASCP_SH_LOAD;
            nxt_st.shreg = {{(CFG_W-1){1'b0}}, 1'b1};
            nxt_st.count = CNT_ONE;
          end else begin
            nxt_st.state = ASCP_SH_SKIP;
          end
        end
        ASCP_SH_LOAD: begin
          nxt_st.shreg = {st_ff.shreg[CFG_W-2:0], cfg.data_bit};
          nxt_st.count = st_ff.count + CNT_ONE;
          if (st_ff.count + CNT_ONE == FRAME_LEN) begin
            nxt_st.done = 1'b1;
            nxt_st.state = ASCP_SH_SKIP;
          end
        end
        ASCP_SH_SKIP: begin
          nxt_st.state = ASCP_SH_SKIP;
        end
        default: begin
          nxt_st.state = ASCP_SH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_ff <= '{state: ASCP_SH_IDLE, shreg: CFG_RESET, count: CNT_ZERO, done: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cfg.frame_done = st_ff.done;
  assign cfg.frame = st_ff.shreg;

endmodule

`default_nettype wire

// [design/ascp_top.sv]
// Configuration logic: pin and serial-port selection of range, mode,
// coding and power-down. Assumes all pins are asynchronous to ref_clk and
// that the serial port clock stays at or below 40 MHz.
// Mode pins pick the source: dedicated pins in hardware mode, the
// register written through the port in software mode.
`timescale 1ns/1ps
`default_nettype none

module ascp_top
  import ascp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic serial_parallel_select,
  input wire logic config_select_a,
  input wire logic pin_range_bipolar,
  input wire logic wide_range_select,
  input wire logic power_down_request,
  input wire logic pin_mode_lowpower,
  input wire logic pin_mode_fast,
  input wire logic output_coding_select,
  input wire logic cfg_serial_in,
  input wire logic cfg_serial_clock,
  input wire logic cfg_port_select_n,
  input wire logic invert_serial_clock,
  output logic config_port_active,
  output logic hw_config_used,
  output logic [CFG_W-1:0] converter_configuration,
  output ascp_range_t active_range,
  output ascp_mode_t active_mode,
  output logic straight_binary,
  output logic converter_power_down,
  output logic config_updated
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [NPINS-1:0] sync1;
    logic [NPINS-1:0] sync2;
    logic sclk_prev;
    logic [CFG_W-1:0] cfg_reg;
    logic port_active;
    logic hw_used;
    ascp_range_t range;
    ascp_mode_t mode;
    logic coding;
    logic pd;
    logic updated;
  } ascp_top_t;

  ascp_top_t st_ff;
  ascp_top_t nxt_st;

  ascp_cfg_if cfg_bus ();

  // Synchronised edge, source and decode signals
  logic [NPINS-1:0] pins_raw;
  logic port_mode_now;
  logic hw_mode_now;
  logic sclk_rise;
  logic sclk_fall;
  logic active_edge;
  logic sel_bip;
  logic sel_wide;
  logic sel_pd;
  logic sel_lp;
  logic sel_fast;
  logic sel_cod;

  // One bundle, so every pin sees the same synchroniser delay
  assign pins_raw[PIN_SPSEL] = serial_parallel_select;
  assign pins_raw[PIN_HWSEL] = config_select_a;
  assign pins_raw[PIN_BIP] = pin_range_bipolar;
  assign pins_raw[PIN_WIDE] = wide_range_select;
  assign pins_raw[PIN_PD] = power_down_request;
  assign pins_raw[PIN_LP] = pin_mode_lowpower;
  assign pins_raw[PIN_FAST] = pin_mode_fast;
  assign pins_raw[PIN_COD] = output_coding_select;
  assign pins_raw[PIN_SIN] = cfg_serial_in;
  assign pins_raw[PIN_SCLK] = cfg_serial_clock;
  assign pins_raw[PIN_SELN] = cfg_port_select_n;
  assign pins_raw[PIN_INV] = invert_serial_clock;

  ////////////////////////////////////////////////////////////////////////
  // Configuration source from the synchronised mode pins

  // Decode and port share these levels, so a mode change never lets the
  // dedicated pins reach the outputs for a cycle in software mode
  assign port_mode_now = st_ff.sync2[PIN_SPSEL] && !st_ff.sync2[PIN_HWSEL];
  assign hw_mode_now = !port_mode_now;

  ////////////////////////////////////////////////////////////////////////
  // Serial clock edge detection on synchronised levels

  // Previous synchronised level gives one-cycle edge pulses
  assign sclk_rise = st_ff.sync2[PIN_SCLK] && !st_ff.sclk_prev;
  assign sclk_fall = !st_ff.sync2[PIN_SCLK] && st_ff.sclk_prev;
  // Polarity chosen by the inversion input; only the selected edge is passed on
  assign active_edge = st_ff.sync2[PIN_INV] ? sclk_fall : sclk_rise;

  ////////////////////////////////////////////////////////////////////////
  // Frame shifter

  // Frames are taken whenever the port is active: no gating by conversion or power-down
  assign cfg_bus.port_active = st_ff.port_active;
  // Select and data pass the same synchroniser as the clock edge
  assign cfg_bus.sel_n = st_ff.sync2[PIN_SELN];
  assign cfg_bus.edge_pulse = active_edge;
  assign cfg_bus.data_bit = st_ff.sync2[PIN_SIN];

  ascp_shift u_shift (
    .ref_clk(ref_clk),
    .rst(rst),
    .cfg(cfg_bus.shifter)
  );

  ////////////////////////////////////////////////////////////////////////
  // Source select and decode

  always_comb begin
    if (hw_mode_now) begin
      // Dedicated pins, synchronised
      sel_bip = st_ff.sync2[PIN_BIP];
      sel_wide = st_ff.sync2[PIN_WIDE];
      sel_pd = st_ff.sync2[PIN_PD];
      sel_lp = st_ff.sync2[PIN_LP];
      sel_fast = st_ff.sync2[PIN_FAST];
      sel_cod = st_ff.sync2[PIN_COD];
    end else begin
      // Register bits written by the last frame
      sel_bip = st_ff.cfg_reg[RANGE_BIP_BIT];
      sel_wide = st_ff.cfg_reg[RANGE_WIDE_BIT];
      sel_pd = st_ff.cfg_reg[PD_BIT];
      sel_lp = st_ff.cfg_reg[MODE_LP_BIT];
      sel_fast = st_ff.cfg_reg[MODE_FAST_BIT];
      sel_cod = st_ff.cfg_reg[CODING_BIT];
    end
  end

  always_comb begin
    nxt_st = st_ff;

    // Two-stage synchronisers and serial clock history
    nxt_st.sync1 = pins_raw;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.sclk_prev = st_ff.sync2[PIN_SCLK];

    // Port lives on the shared data pins: serial and software only
    nxt_st.port_active = port_mode_now;
    nxt_st.hw_used = hw_mode_now;

    // Ninth active edge moves the writable bits into the active set
    nxt_st.updated = cfg_bus.frame_done;
    if (cfg_bus.frame_done) begin
      // Start bit lands high; reserved low bits keep their value
      nxt_st.cfg_reg[CFG_W-1:WRITABLE_LO] = cfg_bus.frame[CFG_W-1:WRITABLE_LO];
    end

    // Input range
    case ({sel_bip, sel_wide})
      2'h0: nxt_st.range = ASCP_RANGE_UNI5;
      2'h1: nxt_st.range = ASCP_RANGE_UNI10;
      2'h2: nxt_st.range = ASCP_RANGE_BIP5;
      2'h3: nxt_st.range = ASCP_RANGE_BIP10;
      default: nxt_st.range = ASCP_RANGE_UNI5;
    endcase

    // Conversion mode; both select bits high is normal as well
    case ({sel_lp, sel_fast})
      2'h0: nxt_st.mode = ASCP_MODE_NORMAL;
      2'h1: nxt_st.mode = ASCP_MODE_WARP;
      2'h2: nxt_st.mode = ASCP_MODE_IMPULSE;
      2'h3: nxt_st.mode = ASCP_MODE_NORMAL;
      default: nxt_st.mode = ASCP_MODE_NORMAL;
    endcase

    // Output coding and power-down
    nxt_st.coding = sel_cod;
    // Shifter is not gated by power-down
    nxt_st.pd = sel_pd;
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  // Reset returns to the hardware-mode view with an all-zero register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_ff <= '{
        sync1: PINS_RESET,
        sync2: PINS_RESET,
        sclk_prev: 1'b0,
        cfg_reg: CFG_RESET,
        port_active: 1'b0,
        hw_used: 1'b1,
        range: ASCP_RANGE_UNI5,
        mode: ASCP_MODE_NORMAL,
        coding: 1'b0,
        pd: 1'b0,
        updated: 1'b0
      };
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops

  assign config_port_active = st_ff.port_active;
  assign hw_config_used = st_ff.hw_used;
  assign converter_configuration = st_ff.cfg_reg;
  assign active_range = st_ff.range;
  assign active_mode = st_ff.mode;
  assign straight_binary = st_ff.coding;
  assign converter_power_down = st_ff.pd;
  assign config_updated = st_ff.updated;

endmodule

`default_nettype wire

// [dv/ascp_props.sv]
// Checker of the configuration outputs.
// Assumes binding into ascp_top.
`timescale 1ns/1ps
`default_nettype none
module ascp_props
  import ascp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic config_port_active,
  input wire logic hw_config_used,
  input wire logic [CFG_W-1:0] converter_configuration,
  input var ascp_range_t active_range,
  input var ascp_mode_t active_mode,
  input wire logic straight_binary,
  input wire logic converter_power_down,
  input wire logic config_updated
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [CFG_W-1:0] q_ff;
  logic [1:0] qm;
  always_ff @(posedge ref_clk) q_ff <= converter_configuration;
  assign qm = q_ff[MODE_LP_BIT:MODE_FAST_BIT];
  ////////////////////////////////////////////////////////////////
  sequence s_sw3;
    config_port_active [*3];
  endsequence
  property p_excl; config_port_active != hw_config_used; endproperty
  property p_rsv; converter_configuration[1:0] == 2'h0; endproperty
  property p_start; config_updated |-> converter_configuration[START_BIT]; endproperty
  property p_hold; $changed(converter_configuration) |-> config_updated; endproperty
  property p_pulse; config_updated |=> !config_updated; endproperty
  property p_port; config_updated |-> $past(config_port_active); endproperty
  property p_range; s_sw3 |-> active_range == ascp_range_t'(q_ff[7:6]); endproperty
  property p_mode;
    s_sw3 |-> active_mode == (qm == 2'h2 ? ASCP_MODE_IMPULSE :
      qm == 2'h1 ? ASCP_MODE_WARP : ASCP_MODE_NORMAL);
  endproperty
  property p_cod;
    s_sw3 |-> straight_binary == q_ff[CODING_BIT] && converter_power_down == q_ff[PD_BIT];
  endproperty
  property p_rst;
    disable iff (1'b0) rst |=> converter_configuration == CFG_RESET && !config_updated;
  endproperty
  a_excl: assert property (p_excl) else $error("port and pin mode overlap");
  a_rsv: assert property (p_rsv) else $error("low bits written");
  a_start: assert property (p_start) else $error("update without start");
  a_hold: assert property (p_hold) else $error("register moved alone");
  a_pulse: assert property (p_pulse) else $error("update too long");
  a_port: assert property (p_port) else $error("update while inactive");
  a_range: assert property (p_range) else $error("range decode");
  a_mode: assert property (p_mode) else $error("mode decode");
  a_cod: assert property (p_cod) else $error("coding or power decode");
  a_rst: assert property (p_rst) else $error("reset value");
endmodule
bind ascp_top ascp_props u_props (.ref_clk, .rst, .config_port_active, .hw_config_used,
  .converter_configuration, .active_range, .active_mode, .straight_binary,
  .converter_power_down, .config_updated);
`default_nettype wire

// [dv/ascp_host.sv]
// Host model driving the serial configuration port.
// Assumes a 32 ns link clock period.
`timescale 1ns/1ps
`default_nettype none
module ascp_host
  import ascp_pkg::*;
(
  input wire logic invert_serial_clock,
  output logic cfg_serial_clock,
  output logic cfg_serial_in,
  output logic cfg_port_select_n
);
  initial begin
    cfg_port_select_n = 1'b1;
    cfg_serial_clock = 1'b0;
    cfg_serial_in = 1'b0;
  end
  // Idle level follows polarity
  always @(invert_serial_clock) if (cfg_port_select_n) cfg_serial_clock = invert_serial_clock;
  task send(input logic [CFG_W-1:0] f, input int n);
    // Bench runs no conversion, so there is no busy window to keep clear
    cfg_port_select_n = 1'b0;
    #20ns;
    for (int i = CFG_W - 1; i > CFG_W - 1 - n; i--) begin
      cfg_serial_in = f[i];
      #16ns cfg_serial_clock = ~invert_serial_clock;
      #16ns cfg_serial_clock = invert_serial_clock;
    end
    #16ns cfg_port_select_n = 1'b1;
    cfg_serial_in = ~cfg_serial_in;
    #20ns;
  endtask
endmodule
`default_nettype wire

// [dv/ascp_top_bench.sv]
// Self-checking bench of the configuration logic.
// Assumes the host model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module ascp_top_bench;
  import ascp_pkg::*;
  logic ref_clk, rst, sps, hws, bip, wide, pdr, lp, fast, cod, inv;
  logic ca, hu, upd, sb, pdo;
  logic [CFG_W-1:0] cfg, f;
  ascp_range_t rng;
  ascp_mode_t md;
  wire logic sclk, sin, seln;
  int bad_count, n_tests, upd_n;
  ascp_top dut (.ref_clk, .rst, .serial_parallel_select(sps), .config_select_a(hws),
    .pin_range_bipolar(bip), .wide_range_select(wide), .power_down_request(pdr),
    .pin_mode_lowpower(lp), .pin_mode_fast(fast), .output_coding_select(cod),
    .cfg_serial_in(sin), .cfg_serial_clock(sclk), .cfg_port_select_n(seln),
    .invert_serial_clock(inv), .config_port_active(ca), .hw_config_used(hu),
    .converter_configuration(cfg), .active_range(rng), .active_mode(md),
    .straight_binary(sb), .converter_power_down(pdo), .config_updated(upd));
  ascp_host host (.invert_serial_clock(inv), .cfg_serial_clock(sclk),
    .cfg_serial_in(sin), .cfg_port_select_n(seln));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (upd === 1'b1) upd_n++;
  ////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  function logic [1:0] em(input logic l, input logic q);
    return (l & !q) ? 2'h1 : (q & !l) ? 2'h2 : 2'h0;
  endfunction
  task outs(input logic [1:0] r, input logic [1:0] m, input logic c, input logic p);
    chk("range", 9'(rng), 9'(r));
    chk("mode", 9'(md), 9'(m));
    chk("coding", 9'(sb), 9'(c));
    chk("pd", 9'(pdo), 9'(p));
  endtask
  initial begin
    #100us;
    bad_count++;
    final_report();
  end
  initial begin
    {rst, sps, hws, bip, wide, pdr, lp, fast, cod, inv} = 10'h200;
    bad_count = 0;
    n_tests = 0;
    upd_n = 0;
    cyc(6);
    chk("reg", cfg, CFG_RESET);
    rst = 1'b0;
    cyc(4);
    chk("hwused", 9'(hu), 9'h001);
    chk("active", 9'(ca), 9'h000);
    outs(2'h0, 2'h0, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      {bip, wide} = i[1:0];
      {pdr, cod} = i[1:0];
      {lp, fast} = i[1:0];
      cyc(5);
      outs(i[1:0], em(i[1], i[0]), i[0], i[1]);
    end
    {sps, hws} = 2'h3;
    cyc(5);
    chk("active", 9'(ca), 9'h000);
    host.send(9'h1FC, 9);
    cyc(4);
    chk("upd", 9'(upd_n), 9'h000);
    outs(2'h3, 2'h0, 1'b1, 1'b1);
    hws = 1'b0;
    cyc(5);
    chk("active", 9'(ca), 9'h001);
    chk("hwused", 9'(hu), 9'h000);
    outs(2'h0, 2'h0, 1'b0, 1'b0);
    for (int i = 3; i >= 0; i--) begin
      inv = i[0];
      cyc(4);
      f = {1'b1, i[1:0], i[1], i[1:0], i[0], 2'h3};
      host.send(f, 9);
      cyc(2);
      chk("reg", cfg, {f[8:2], 2'h0});
      outs(i[1:0], em(i[1], i[0]), i[0], i[1]);
    end
    host.send(9'h0FC, 9);
    host.send(9'h1FC, 8);
    cyc(4);
    chk("reg", cfg, 9'h100);
    chk("upd", 9'(upd_n), 9'h004);
    rst = 1'b1;
    cyc(2);
    chk("reg", cfg, CFG_RESET);
    rst = 1'b0;
    repeat (6) begin
      cyc(1);
      outs(2'h0, 2'h0, 1'b0, 1'b0);
    end
    host.send(9'h1FC, 9);
    cyc(2);
    chk("reg", cfg, 9'h1FC);
    outs(2'h3, 2'h0, 1'b1, 1'b1);
    chk("upd", 9'(upd_n), 9'h005);
    final_report();
  end
endmodule
`default_nettype wire
